// file: core/mss_defines.vh
/*
 * Constants of the synchronized start coordinator: register offsets,
 * field positions, reset values, axis encodings and timing figures.
 * Assumes an APB slave with 32-bit data and byte addresses.
 */
// Operation
// - List up to eight axes, count defaults one
// - Arm listed axes, gather readiness, start together
// - Axis state must be a motion-capable state
// - Axis must hold a qualifying pending command
// - Error if not all ready within timeout
// - Zero timeout means a five-minute limit
// - Exact flag starts at timeout, else immediately
// - Stop, reset or power commands abort
// - Faulting axis stops alone, others continue
// - Done once all listed axes began or faulted
// - Busy from trigger until action completes
// - Warning, error and fault code, zero initially
`ifndef MSS_DEFINES_VH
`define MSS_DEFINES_VH

// Register byte offsets
`define MSS_OFS_CTRL      8'h00
`define MSS_OFS_TIMEOUT   8'h04
`define MSS_OFS_STATUS    8'h08
`define MSS_OFS_INT_STAT  8'h0C
`define MSS_OFS_INT_MASK  8'h10
`define MSS_OFS_READY     8'h14

// Control fields
`define MSS_CTRL_EXEC     0
`define MSS_CTRL_EXACT    1
`define MSS_CTRL_CNT_LO   4
`define MSS_CTRL_CNT_HI   7
`define MSS_CNT_RESET     4'h1
`define MSS_CNT_MAX       4'h8

// Status fields
`define MSS_ST_DONE       0
`define MSS_ST_BUSY       1
`define MSS_ST_WARN       2
`define MSS_ST_ERR        3
`define MSS_ST_CODE_LO    16
`define MSS_ST_CODE_HI    31

// Interrupt bits
`define MSS_IRQ_DONE      0
`define MSS_IRQ_ERR       1
`define MSS_IRQ_WARN      2

// Fault codes
`define MSS_FC_NONE       16'h0000
`define MSS_FC_TIMEOUT    16'h0001
`define MSS_FC_ABORT      16'h0002
`define MSS_FC_LOW_TIME   16'h0010
`define MSS_FC_AXIS_FAULT 16'h0020

// Axis state encodings
`define MSS_AS_STANDSTILL 3'h1
`define MSS_AS_P2P        3'h2
`define MSS_AS_VELOCITY   3'h3
`define MSS_AS_COUPLED    3'h4

// Qualifying pending commands
`define MSS_CMD_ABS       4'h1
`define MSS_CMD_REL       4'h2
`define MSS_CMD_ADD       4'h3
`define MSS_CMD_SUPER     4'h4
`define MSS_CMD_VEL       4'h5
`define MSS_CMD_CAM       4'h6
`define MSS_CMD_GEAR      4'h7
`define MSS_CMD_GEAR_POS  4'h8

// Timing
`define MSS_CLK_NS        50
`define MSS_TICK_NS       1000000
`define MSS_TIMEOUT_MIN   16'h0005
`define MSS_TIMEOUT_RESET 16'h0000
`define MSS_ZERO_LIMIT_MS 19'd300000

`endif

// file: core/mss_sync_start.v
/*
 * Synchronized start coordinator for up to eight motion axes, with
 * APB register access and a masked level interrupt.
 * Assumes each axis reports state, pending command, start and fault,
 * and that abort commands arrive as one-cycle pulses.
 */
`timescale 1ns/1ns
`include "mss_defines.vh"
module mss_sync_start #(
   parameter NAX      = 8,                                 // Axis slots
   parameter TICK_DIV = `MSS_TICK_NS / `MSS_CLK_NS          // Cycles per ms
)(
   input  wire              clk,            // System clock
   input  wire              rst,            // Synchronous reset
   input  wire              psel,           // APB select
   input  wire              penable,        // APB enable
   input  wire              pwrite,         // APB direction
   input  wire [7:0]        paddr,          // APB byte address
   input  wire [31:0]       pwdata,         // APB write data
   output reg  [31:0]       prdata,         // APB read data
   output reg               pready,         // APB ready
   output reg               pslverr,        // APB error
   input  wire [3*NAX-1:0]  axisState,      // Per-axis state code
   input  wire [NAX-1:0]    cmdPending,     // Pending command held
   input  wire [4*NAX-1:0]  cmdCode,        // Pending command code
   input  wire [NAX-1:0]    haltCmd,        // Halt executed
   input  wire [NAX-1:0]    axisResetCmd,   // Axis reset executed
   input  wire [NAX-1:0]    drivePowerCmd,  // Power command executed
   input  wire              moduleResetCmd, // Module reset executed
   input  wire [NAX-1:0]    axisBegan,      // Axis began its motion
   input  wire [NAX-1:0]    axisFault,      // Axis faulted at start
   output reg  [NAX-1:0]    syncArm,        // Next command is the synced one
   output reg               syncGo,         // Common start pulse
   output reg               done,           // All listed axes started or faulted
   output reg               busy,           // Action in progress
   output reg               warning,        // Warning flag
   output reg               error,          // Error flag
   output reg  [15:0]       faultCode,      // Fault or warning code
   output reg               irq             // Level interrupt
);
   localparam S_IDLE = 2'd0;
   localparam S_WAIT = 2'd1;
   localparam S_HOLD = 2'd2;
   localparam S_RUN  = 2'd3;

   reg  [1:0]     state_q;
   reg  [1:0]     state_d;
   reg            execBit_q;
   reg            execPrev_q;
   reg            exact_q;
   reg  [3:0]     count_q;
   reg  [15:0]    timeout_q;
   reg  [2:0]     intStat_q;
   reg  [2:0]     intMask_q;
   reg  [18:0]    elapsed_q;
   reg  [18:0]    limit_q;
   reg  [NAX-1:0] list_q;
   reg  [NAX-1:0] began_q;
   reg            runExact_q;
   reg  [NAX-1:0] listMask;
   reg  [NAX-1:0] axisReady;
   reg  [3:0]     cntEff;
   reg  [2:0]     st;
   reg  [3:0]     cc;
   wire           msTick;
   wire           setup;
   wire           wrDone;
   wire           trigger;
   wire           abortHit;
   wire           allReady;
   wire           allBegan;
   wire           limitHit;
   wire           overLimit;
   wire [2:0]     evt;
   integer        i;
   integer        k;

   // Setup phase and completed write
   assign setup  = psel & ~penable;
   assign wrDone = psel & penable & pready & pwrite;

   // Execute rising edge starts the action only from idle
   assign trigger = execBit_q & ~execPrev_q & (state_q == S_IDLE);

   // Listed slots from the count field, clamped to the slot range
   always @*
   begin
      if (count_q == 4'h0)
         cntEff = `MSS_CNT_RESET;
      else if (count_q > `MSS_CNT_MAX)
         cntEff = `MSS_CNT_MAX;
      else
         cntEff = count_q;
      for (i = 0; i < NAX; i = i + 1)
         listMask[i] = (i < cntEff);
   end

   // Per-axis qualification of state and pending command
   always @*
   begin
      axisReady = {NAX{1'b0}};
      st = 3'h0;
      cc = 4'h0;
      for (k = 0; k < NAX; k = k + 1)
      begin
         st = axisState[3*k +: 3];
         cc = cmdCode[4*k +: 4];
         axisReady[k] = cmdPending[k]
            && (st == `MSS_AS_STANDSTILL || st == `MSS_AS_P2P
             || st == `MSS_AS_VELOCITY   || st == `MSS_AS_COUPLED)
            && (cc >= `MSS_CMD_ABS && cc <= `MSS_CMD_GEAR_POS);
      end
   end

   // Coordination terms over the listed axes
   assign allReady  = &(axisReady | ~list_q);
   assign allBegan  = &(began_q | axisBegan | axisFault | ~list_q);
   assign abortHit  = moduleResetCmd
                    | (|((haltCmd | axisResetCmd | drivePowerCmd) & list_q));
   assign limitHit  = (elapsed_q >= limit_q);
   assign overLimit = (elapsed_q > limit_q);

   // Millisecond tick, realigned at each trigger
   mss_tick_div #(
      .DIV     (TICK_DIV)
   ) u_tick (
      .clk     (clk),
      .rst     (rst),
      .restart (trigger),
      .tick    (msTick)
   );

   // Next state of the coordination sequence
   always @*
   begin
      state_d = state_q;
      case (state_q)
         S_IDLE:
            if (trigger)
               state_d = S_WAIT;
         S_WAIT:
            if (abortHit)
               state_d = S_IDLE;
            else if (allReady && runExact_q)
               state_d = S_HOLD;
            else if (allReady)
               state_d = S_RUN;
            else if (limitHit)
               state_d = S_IDLE;
         S_HOLD:
            if (abortHit || limitHit)
               state_d = abortHit ? S_IDLE : S_RUN;
         S_RUN:
            if (abortHit || allBegan || overLimit)
               state_d = S_IDLE;
         default:
            state_d = S_IDLE;
      endcase
   end

   // Sequence registers and outputs toward the axes
   always @(posedge clk)
   begin
      if (rst)
      begin
         state_q    <= S_IDLE;
         elapsed_q  <= 19'd0;
         limit_q    <= 19'd0;
         list_q     <= {NAX{1'b0}};
         began_q    <= {NAX{1'b0}};
         runExact_q <= 1'b0;
         syncArm    <= {NAX{1'b0}};
         syncGo     <= 1'b0;
         done       <= 1'b0;
         busy       <= 1'b0;
         warning    <= 1'b0;
         error      <= 1'b0;
         faultCode  <= `MSS_FC_NONE;
      end
      else
      begin
         state_q <= state_d;
         syncGo  <= 1'b0;
         if (msTick && state_q != S_IDLE && elapsed_q != 19'h7_FFFF)
            elapsed_q <= elapsed_q + 19'd1;
         if (trigger)
         begin
            elapsed_q  <= 19'd0;
            list_q     <= listMask;
            began_q    <= {NAX{1'b0}};
            runExact_q <= exact_q;
            syncArm    <= listMask;
            busy       <= 1'b1;
            done       <= 1'b0;
            error      <= 1'b0;
            if (timeout_q == `MSS_TIMEOUT_RESET)
               limit_q <= `MSS_ZERO_LIMIT_MS;
            else
               limit_q <= {3'b000, timeout_q};
            if (timeout_q != `MSS_TIMEOUT_RESET && timeout_q < `MSS_TIMEOUT_MIN)
            begin
               warning   <= 1'b1;
               faultCode <= `MSS_FC_LOW_TIME;
            end
            else
            begin
               warning   <= 1'b0;
               faultCode <= `MSS_FC_NONE;
            end
         end
         // Abort or timeout ends the action with an error
         if (state_q != S_IDLE && state_d == S_IDLE && !(state_q == S_RUN && allBegan
             && !abortHit))
         begin
            busy      <= 1'b0;
            done      <= 1'b0;
            error     <= 1'b1;
            syncArm   <= {NAX{1'b0}};
            faultCode <= abortHit ? `MSS_FC_ABORT : `MSS_FC_TIMEOUT;
         end
         // Common start once coordination allows
         if (state_d == S_RUN && state_q != S_RUN)
         begin
            syncGo  <= 1'b1;
            syncArm <= {NAX{1'b0}};
         end
         if (state_q == S_RUN)
         begin
            began_q <= began_q | ((axisBegan | axisFault) & list_q);
            if (|(axisFault & list_q))
            begin
               warning   <= 1'b1;
               faultCode <= `MSS_FC_AXIS_FAULT;
            end
            if (allBegan && !abortHit)
            begin
               busy    <= 1'b0;
               done    <= 1'b1;
            end
         end
      end
   end

   // Interrupt events from flag rises
   assign evt[`MSS_IRQ_DONE] = (state_q == S_RUN) & allBegan & ~abortHit;
   assign evt[`MSS_IRQ_ERR]  = (state_q != S_IDLE) & (state_d == S_IDLE) & ~evt[0];
   assign evt[`MSS_IRQ_WARN] = (trigger & (timeout_q != `MSS_TIMEOUT_RESET)
                               & (timeout_q < `MSS_TIMEOUT_MIN))
                             | ((state_q == S_RUN) & (|(axisFault & list_q)));

   // Software registers and interrupt status
   always @(posedge clk)
   begin
      if (rst)
      begin
         execBit_q  <= 1'b0;
         execPrev_q <= 1'b0;
         exact_q    <= 1'b0;
         count_q    <= `MSS_CNT_RESET;
         timeout_q  <= `MSS_TIMEOUT_RESET;
         intStat_q  <= 3'b000;
         intMask_q  <= 3'b000;
         irq        <= 1'b0;
      end
      else
      begin
         execPrev_q <= execBit_q;
         if (wrDone && paddr == `MSS_OFS_CTRL)
         begin
            execBit_q <= pwdata[`MSS_CTRL_EXEC];
            exact_q   <= pwdata[`MSS_CTRL_EXACT];
            count_q   <= pwdata[`MSS_CTRL_CNT_HI:`MSS_CTRL_CNT_LO];
         end
         if (wrDone && paddr == `MSS_OFS_TIMEOUT)
            timeout_q <= pwdata[15:0];
         if (wrDone && paddr == `MSS_OFS_INT_MASK)
            intMask_q <= pwdata[2:0];
         // Write one clears, a new event in the same cycle wins
         if (wrDone && paddr == `MSS_OFS_INT_STAT)
            intStat_q <= (intStat_q & ~pwdata[2:0]) | evt;
         else
            intStat_q <= intStat_q | evt;
         irq <= |(intStat_q & intMask_q);
      end
   end

   // APB answer: ready in the first access cycle
   always @(posedge clk)
   begin
      if (rst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= setup;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (setup)
         begin
            case (paddr)
               `MSS_OFS_CTRL:
                  prdata <= {24'h00_0000, count_q, 2'b00, exact_q, execBit_q};
               `MSS_OFS_TIMEOUT:
                  prdata <= {16'h0000, timeout_q};
               `MSS_OFS_STATUS:
                  prdata <= {faultCode, 12'h000, error, warning, busy, done};
               `MSS_OFS_INT_STAT:
                  prdata <= {29'h000_0000, intStat_q};
               `MSS_OFS_INT_MASK:
                  prdata <= {29'h000_0000, intMask_q};
               `MSS_OFS_READY:
                  prdata <= {{(32-NAX){1'b0}}, axisReady};
               default:
                  pslverr <= 1'b1;
            endcase
         end
      end
   end
endmodule // mss_sync_start

// file: core/mss_tick_div.v
/*
 * Millisecond enable divider for the coordinator.
 * Assumes one clock; restart realigns the tick to the trigger.
 */
`timescale 1ns/1ns
module mss_tick_div #(
   parameter DIV = 20000              // Clock cycles per tick
)(
   input  wire clk,                   // System clock
   input  wire rst,                   // Synchronous reset
   input  wire restart,               // Restart counting
   output reg  tick                   // One-cycle tick pulse
);
   reg [31:0] cnt_q;

   // Divide the clock down to one pulse per period
   always @(posedge clk)
   begin
      if (rst || restart)
      begin
         cnt_q <= 32'h0000_0000;
         tick  <= 1'b0;
      end
      else if (cnt_q == DIV - 1)
      begin
         cnt_q <= 32'h0000_0000;
         tick  <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_q + 32'h0000_0001;
         tick  <= 1'b0;
      end
   end
endmodule // mss_tick_div

// file: testbench/mss_axis_model.sv
/* Behavioural axis group facing the coordinator.
   Assumes the bench sets states, commands, lag and failing axes. */
`timescale 1ns/1ns
module mss_axis_model #(
   parameter NAX = 8                        // Axis slots
)(
   input  wire              clk,            // Clock
   input  wire              rst,            // Reset
   input  wire [NAX-1:0]    syncArm,        // Armed axes
   input  wire              syncGo,         // Common start
   input  wire [3*NAX-1:0]  stateCfg,       // States to report
   input  wire [4*NAX-1:0]  codeCfg,        // Commands to report
   input  wire [NAX-1:0]    pendCfg,        // Command held
   input  wire [NAX-1:0]    faultCfg,       // Axes failing at start
   input  wire [7:0]        lagCfg,         // Cycles from go to motion
   output wire [3*NAX-1:0]  axisState,      // Axis state
   output wire [4*NAX-1:0]  cmdCode,        // Pending command
   output wire [NAX-1:0]    cmdPending,     // Pending flag
   output reg  [NAX-1:0]    axisBegan,      // Motion began
   output reg  [NAX-1:0]    axisFault       // Fault while starting
);
   reg [NAX-1:0] armed_q;
   reg [8:0]     lag_q;
   // Reported state and held command
   assign axisState = stateCfg;
   assign cmdCode = codeCfg;
   assign cmdPending = pendCfg;
   // Began or fault pulses a set lag after the common start
   always @(posedge clk)
   begin
      axisBegan <= {NAX{1'b0}};
      axisFault <= {NAX{1'b0}};
      if (rst)
      begin
         armed_q <= {NAX{1'b0}};
         lag_q <= 9'h000;
      end
      else
      begin
         if (|syncArm)
            armed_q <= syncArm;
         if (syncGo)
            lag_q <= {1'b0, lagCfg} + 9'h001;
         else if (lag_q != 9'h000)
            lag_q <= lag_q - 9'h001;
         if (lag_q == 9'h001)
         begin
            axisBegan <= armed_q & ~faultCfg;
            axisFault <= armed_q & faultCfg;
         end
      end
   end
endmodule // mss_axis_model

// file: testbench/mss_sync_props.sv
/* Port checker for the sync start coordinator.
   Assumes binding onto mss_sync_start, one clock, synchronous reset. */
`timescale 1ns/1ns
module mss_sync_props #(
   parameter NAX = 8                    // Axis slots
)(
   input wire           clk,            // Clock
   input wire           rst,            // Reset
   input wire           moduleResetCmd, // Module reset
   input wire [NAX-1:0] syncArm,        // Armed axes
   input wire           syncGo,         // Start pulse
   input wire           done,           // Done
   input wire           busy,           // Busy
   input wire           warning,        // Warning
   input wire           error,          // Error
   input wire [15:0]    faultCode       // Code
);
   reg goSeen_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Remembers a start pulse within the current action
   always @(posedge clk)
   begin
      if (rst || $rose(busy))
         goSeen_q <= 1'b0;
      else if (syncGo)
         goSeen_q <= 1'b1;
   end
   a_reset_quiet: assert property (disable iff (1'b0) rst |=>
      !busy && !done && !error && !warning && faultCode == 16'h0000)
      else $error("outputs not cleared by reset");
   a_go_in_action: assert property (syncGo |-> busy && !done)
      else $error("start pulse outside an action");
   a_go_one_cycle: assert property (syncGo |=> !syncGo)
      else $error("start pulse longer than one cycle");
   a_arm_in_action: assert property (|syncArm |-> busy)
      else $error("axes armed while idle");
   a_done_idle: assert property (done |-> !busy && !error)
      else $error("done together with busy or error");
   a_done_after_go: assert property ($rose(done) |-> goSeen_q)
      else $error("done without a start pulse");
   a_abort_stops: assert property (busy && moduleResetCmd |->
      ##[1:3] (!busy && error && faultCode == 16'h0002))
      else $error("abort did not end the action");
   a_err_ends: assert property ($rose(error) |-> !busy && !done &&
      (faultCode == 16'h0001 || faultCode == 16'h0002))
      else $error("error raised with a wrong code or state");
   c_go: cover property (syncGo);
   c_done: cover property ($rose(done));
   c_error: cover property ($rose(error));
endmodule // mss_sync_props
bind mss_sync_start mss_sync_props #(.NAX(NAX)) u_props (.clk(clk), .rst(rst),
   .moduleResetCmd(moduleResetCmd), .syncArm(syncArm), .syncGo(syncGo), .done(done),
   .busy(busy), .warning(warning), .error(error), .faultCode(faultCode));

// file: testbench/multi_axis_sync_start_tb_top.sv
/* Self-checking bench of the sync start coordinator.
   Assumes the axis model in its own file and a 20 MHz clock. */
`timescale 1ns/1ns
`include "mss_defines.vh"
module multi_axis_sync_start_tb_top;
   localparam NAX = 8;
   localparam TD  = 10;                       // Cycles per ms here
   logic             clk, rst, psel, penable, pwrite, moduleResetCmd, slvErr;
   logic [7:0]       paddr, lagCfg, seed, pendCfg, faultCfg;
   logic [7:0]       haltCmd, axisResetCmd, drivePowerCmd, armSeen;
   logic [31:0]      pwdata, rd;
   logic [23:0]      s;
   logic [31:0]      c, stateCfg, codeCfg;
   wire  [31:0]      prdata;
   wire  [15:0]      faultCode;
   wire  [7:0]       syncArm, cmdPending, axisBegan, axisFault;
   wire  [23:0]      axisState;
   wire  [31:0]      cmdCode;
   wire              pready, pslverr, syncGo, done, busy, warning, error, irq;
   int               n_errors, check_count, cyc, goAt, i, j, r;
   logic [3:0]       cnt;
   mss_sync_start #(.NAX(NAX), .TICK_DIV(TD)) u_mss_sync_start (.clk(clk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .axisState(axisState),
      .cmdPending(cmdPending), .cmdCode(cmdCode), .haltCmd(haltCmd),
      .axisResetCmd(axisResetCmd), .drivePowerCmd(drivePowerCmd),
      .moduleResetCmd(moduleResetCmd), .axisBegan(axisBegan), .axisFault(axisFault),
      .syncArm(syncArm), .syncGo(syncGo), .done(done), .busy(busy), .warning(warning),
      .error(error), .faultCode(faultCode), .irq(irq));
   mss_axis_model #(.NAX(NAX)) u_mss_axis_model (.clk(clk), .rst(rst), .syncArm(syncArm),
      .syncGo(syncGo), .stateCfg(stateCfg[23:0]), .codeCfg(codeCfg), .pendCfg(pendCfg),
      .faultCfg(faultCfg), .lagCfg(lagCfg), .axisState(axisState), .cmdCode(cmdCode),
      .cmdPending(cmdPending), .axisBegan(axisBegan), .axisFault(axisFault));
   // Clock
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Cycles since the action began, go instant and armed list
   always @(posedge clk)
   begin
      cyc <= busy ? cyc + 1 : 0;
      if (syncGo)
         goAt <= cyc;
      if (busy && cyc == 0)
         armSeen <= syncArm;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   function automatic logic [7:0] qual(input logic [23:0] st, input logic [31:0] cd,
                                       input logic [7:0] p);
      qual = 8'h00;
      for (int k = 0; k < NAX; k++)
         qual[k] = p[k] && st[3*k +: 3] >= `MSS_AS_STANDSTILL && st[3*k +: 3] <= `MSS_AS_COUPLED
                   && cd[4*k +: 4] >= `MSS_CMD_ABS && cd[4*k +: 4] <= `MSS_CMD_GEAR_POS;
   endfunction
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One APB transfer, waiting a bounded time for ready
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 16)
      begin
         n++;
         @(posedge clk);
      end
      rd = prdata;
      slvErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      if (n >= 16)
      begin
         n_errors++;
         complete_run();
      end
   endtask
   // Random qualifying axes except those marked bad
   task automatic cfgAxes(input logic [7:0] bad);
      for (int k = 0; k < NAX; k++)
      begin
         seed = lfsr(seed);
         s[3*k +: 3] = bad[k] ? 3'h0 : 3'h1 + {1'b0, seed[1:0]};
         c[4*k +: 4] = 4'h1 + {1'b0, seed[4:2]};
      end
      stateCfg <= {8'h00, s};
      codeCfg <= c;
      pendCfg <= 8'hFF;
      lagCfg <= {5'h00, seed[2:0]};   // Lag kept under one tick
   endtask
   task automatic launch(input logic [3:0] n, input logic ex, input logic [15:0] ms);
      apb(`MSS_OFS_TIMEOUT, 1'b1, {16'h0000, ms});
      apb(`MSS_OFS_CTRL, 1'b1, {24'h00_0000, n, 2'b00, ex, 1'b0});
      apb(`MSS_OFS_CTRL, 1'b1, {24'h00_0000, n, 2'b00, ex, 1'b1});
   endtask
   // Bounded wait for the action to end, then status compare
   task automatic finish(input logic [15:0] code, input logic [3:0] flags);
      int n;
      n = 0;
      repeat (3) @(posedge clk);
      while (busy !== 1'b0 && n < 4000)
      begin
         n++;
         @(posedge clk);
      end
      if (n >= 4000)
      begin
         n_errors++;
         complete_run();
      end
      apb(`MSS_OFS_STATUS, 1'b0, 32'h0000_0000);
      chk(rd, {code, 12'h000, flags});
   endtask
   initial
   begin
      {psel, penable, pwrite, moduleResetCmd, slvErr} = 5'h00;
      {paddr, pwdata, haltCmd, axisResetCmd, drivePowerCmd, faultCfg, lagCfg} = 0;
      {stateCfg, codeCfg, pendCfg, s, c, rd} = 0;
      {n_errors, check_count} = 0;
      seed = 8'h52;
      rst = 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk({busy, done, warning, error, irq, faultCode}, 32'h0000_0000);
      apb(`MSS_OFS_CTRL, 1'b0, 32'h0000_0000);
      chk(rd, 32'h0000_0010);
      apb(8'h18, 1'b0, 32'h0000_0000);
      chk({slvErr, rd[30:0]}, 32'h8000_0000);
      for (i = 0; i < 2; i++)
      begin
         apb(`MSS_OFS_CTRL, 1'b1, i ? 32'h0000_00F0 : 32'h0000_0000);
         apb(`MSS_OFS_CTRL, 1'b0, 32'h0000_0000);
         chk(rd[7:4], i ? 4'hF : 4'h0);
      end
      // Qualification over every state and command code
      for (i = 0; i < 16; i++)
      begin
         for (j = 0; j < NAX; j++)
         begin
            s[3*j +: 3] = 3'(i + 2 * j);
            c[4*j +: 4] = 4'(i + j);
         end
         seed = lfsr(seed);
         stateCfg <= {8'h00, s};
         codeCfg <= c;
         pendCfg <= seed;
         @(posedge clk);
         apb(`MSS_OFS_READY, 1'b0, 32'h0000_0000);
         chk(rd, {24'h00_0000, qual(s, c, seed)});
      end
      apb(`MSS_OFS_INT_MASK, 1'b1, 32'h0000_0007);
      // Prompt starts with random lists, full list first
      for (r = 0; r < 3; r++)
      begin
         cfgAxes(8'h00);
         cnt = r ? 4'h1 + {1'b0, seed[7:5]} : 4'hF;
         launch(cnt, 1'b0, 16'h0014);
         finish(`MSS_FC_NONE, 4'b0001);
         chk(armSeen, 8'hFF >> (4'h8 - (cnt > 4'h8 ? 4'h8 : cnt)));
         chk(goAt < TD, 1'b1);
         chk(irq, 1'b1);
         apb(`MSS_OFS_INT_STAT, 1'b1, 32'h0000_0007);
         repeat (3) @(posedge clk);
         chk(irq, 1'b0);
      end
      // Exact start at the shortest legal window
      cfgAxes(8'h00);
      launch(4'h3, 1'b1, 16'h0005);
      finish(`MSS_FC_NONE, 4'b0001);
      chk(goAt >= 5 * TD - 3 && goAt <= 5 * TD + 3, 1'b1);
      // Timeout with the error interrupt masked, then unmasked
      apb(`MSS_OFS_INT_MASK, 1'b1, 32'h0000_0000);
      cfgAxes(8'h02);
      launch(4'h2, 1'b0, 16'h0005);
      finish(`MSS_FC_TIMEOUT, 4'b1000);
      chk(irq, 1'b0);
      apb(`MSS_OFS_INT_MASK, 1'b1, 32'h0000_0002);
      repeat (3) @(posedge clk);
      chk(irq, 1'b1);
      apb(`MSS_OFS_INT_STAT, 1'b1, 32'h0000_0007);
      repeat (3) @(posedge clk);
      chk(irq, 1'b0);
      // Every abort kind during a zero-timeout wait (five-minute limit)
      for (i = 0; i < 4; i++)
      begin
         cfgAxes(8'h01);
         launch(4'h4, 1'b0, 16'h0000);
         repeat (100) @(posedge clk);
         chk(busy, 1'b1);
         haltCmd <= i == 0 ? 8'h04 : 8'h00;
         axisResetCmd <= i == 1 ? 8'h04 : 8'h00;
         drivePowerCmd <= i == 2 ? 8'h04 : 8'h00;
         moduleResetCmd <= i == 3;
         @(posedge clk);
         {haltCmd, axisResetCmd, drivePowerCmd, moduleResetCmd} <= 25'h000_0000;
         finish(`MSS_FC_ABORT, 4'b1000);
      end
      // Axis failing at start, then a too short window
      cfgAxes(8'h00);
      faultCfg <= 8'h02;
      launch(4'h3, 1'b0, 16'h0014);
      finish(`MSS_FC_AXIS_FAULT, 4'b0101);
      faultCfg <= 8'h00;
      launch(4'h1, 1'b0, 16'h0003);
      finish(`MSS_FC_LOW_TIME, 4'b0101);
      complete_run();
   end
endmodule // multi_axis_sync_start_tb_top
